// >>> hw/sgp_pkg.sv
// Shared constants and types of the six-pin general purpose port.
// Assumes a 32-bit APB register bus and six pads on the far side.
package sgp_pkg;

  localparam int unsigned NPINS = 6;

  // Register byte offsets, one aligned word each
  localparam logic [7:0] OFF_LEVEL  = 8'h00;
  localparam logic [7:0] OFF_DIR    = 8'h04;
  localparam logic [7:0] OFF_LATCH  = 8'h08;
  localparam logic [7:0] OFF_ANALOG = 8'h0C;
  localparam logic [7:0] OFF_ODRAIN = 8'h10;
  localparam logic [7:0] OFF_PULLUP = 8'h14;
  localparam logic [7:0] OFF_PERIPH = 8'h18;

  // Pin three has no output driver
  localparam logic [5:0] INPUT_ONLY_MASK = 6'h08;
  // Pins that carry an analog function
  localparam logic [5:0] ANALOG_CAPABLE  = 6'h17;

  // Values after reset
  localparam logic [5:0] RESET_DIR    = 6'h3F;
  localparam logic [5:0] RESET_LATCH  = 6'h00;
  localparam logic [5:0] RESET_ANALOG = 6'h17;
  localparam logic [5:0] RESET_ODRAIN = 6'h00;
  localparam logic [5:0] RESET_PULLUP = 6'h3F;
  localparam logic [5:0] RESET_PERIPH = 6'h00;

  // What the port drives towards its pads
  typedef struct packed {
    logic [5:0] out;
    logic [5:0] oe_n;
    logic [5:0] pu_en;
    logic [5:0] ibuf_en;
  } sgp_pad_t;

  localparam sgp_pad_t RESET_PAD = '{
    out:     6'h00,
    oe_n:    6'h3F,
    pu_en:   6'h3F,
    ibuf_en: 6'h28
  };

endpackage

// >>> hw/sgp_sync.sv
// Two-stage synchroniser for a bus of independent level inputs.
// Assumes each bit is an unrelated slow level; no word coherence.
`timescale 1ns/1ps
`default_nettype none
module sgp_sync #(
  parameter int unsigned W = 6
) (
  input  wire logic         CLOCK,
  input  wire logic         RST_N,
  input  wire logic [W-1:0] D,
  output var  logic [W-1:0] Q
);

  logic [W-1:0] meta_q;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
          meta_q[i] <= 1'b0;
          Q[i]      <= 1'b0;
        end else begin
          meta_q[i] <= D[i];
          Q[i]      <= meta_q[i];
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// >>> hw/sgp_port.sv
// Six-pin general purpose port with APB register access.
// Assumes pads resolve their own level from out and oe_n, and that
// software keeps analog pins configured as inputs.
`timescale 1ns/1ps
`default_nettype none
module sgp_port
  import sgp_pkg::*;
#(
  parameter logic [5:0] MERGE_MASK = 6'h3F
) (
  input  wire logic        CLOCK,
  input  wire logic        RST_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output var  logic [31:0] PRDATA,
  output var  logic        PREADY,
  output var  logic        PSLVERR,
  input  wire logic [5:0]  PAD_IN,
  input  wire logic [5:0]  PERIPH_DATA,
  output var  sgp_pad_t    PAD
);

  logic [5:0]  dir_q;
  logic [5:0]  lat_q;
  logic [5:0]  ans_q;
  logic [5:0]  od_q;
  logic [5:0]  wpu_q;
  logic [5:0]  pen_q;
  logic [5:0]  pin_s;
  logic [5:0]  wdata6;
  logic [5:0]  lat_d;
  logic [5:0]  drive;
  logic [31:0] rd_d;
  logic        hit;
  logic        access;
  logic        wr_fire;
  sgp_pad_t    pad_d;

  // Pads are sampled only through the synchroniser
  sgp_sync #(
    .W (NPINS)
  ) u_sync (
    .CLOCK (CLOCK),
    .RST_N (RST_N),
    .D     (PAD_IN),
    .Q     (pin_s)
  );

  assign wdata6  = PWDATA[5:0];
  assign access  = PSEL & PENABLE & ~PREADY;
  assign wr_fire = PSEL & PENABLE & PREADY & PWRITE & hit;

  // A port write always merges what the synchronised pins show, two edges behind the pads, so bits
  // outside the merge mask follow the pins, not the old latch
  assign lat_d = (pin_s & ~MERGE_MASK) | (wdata6 & MERGE_MASK);

  always_comb begin
    rd_d = 32'h0000_0000;
    hit  = 1'b1;
    unique case (PADDR)
      OFF_LEVEL:  rd_d[5:0] = pin_s & ~ans_q;
      OFF_DIR:    rd_d[5:0] = dir_q | INPUT_ONLY_MASK;
      OFF_LATCH:  rd_d[5:0] = lat_q;
      OFF_ANALOG: rd_d[5:0] = ans_q;
      OFF_ODRAIN: rd_d[5:0] = od_q;
      OFF_PULLUP: rd_d[5:0] = wpu_q;
      OFF_PERIPH: rd_d[5:0] = pen_q;
      default:    hit       = 1'b0;
    endcase
  end

  // One wait state: answer in the cycle after the first access cycle
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= access;
      PRDATA  <= access ? rd_d : 32'h0000_0000;
      PSLVERR <= access & ~hit;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      dir_q <= RESET_DIR;
    end else if (wr_fire && PADDR == OFF_DIR) begin
      dir_q <= wdata6 | INPUT_ONLY_MASK;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      lat_q <= RESET_LATCH;
    end else if (wr_fire && (PADDR == OFF_LEVEL || PADDR == OFF_LATCH)) begin
      lat_q <= lat_d;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      ans_q <= RESET_ANALOG;
    end else if (wr_fire && PADDR == OFF_ANALOG) begin
      ans_q <= wdata6 & ANALOG_CAPABLE;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      od_q  <= RESET_ODRAIN;
      wpu_q <= RESET_PULLUP;
      pen_q <= RESET_PERIPH;
    end else if (wr_fire) begin
      if (PADDR == OFF_ODRAIN) begin
        od_q <= wdata6;
      end
      if (PADDR == OFF_PULLUP) begin
        wpu_q <= wdata6;
      end
      if (PADDR == OFF_PERIPH) begin
        pen_q <= wdata6;
      end
    end
  end

  // Analog selection is deliberately absent from the driver path: a
  // pin with direction zero keeps driving even in analog mode
  always_comb begin
    drive         = (pen_q & PERIPH_DATA) | (~pen_q & lat_q);
    pad_d.oe_n    = dir_q | INPUT_ONLY_MASK | (od_q & drive);
    pad_d.out     = drive & ~od_q;
    pad_d.pu_en   = wpu_q & (dir_q | INPUT_ONLY_MASK);
    pad_d.ibuf_en = ~ans_q;
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      PAD <= RESET_PAD;
    end else begin
      PAD <= pad_d;
    end
  end

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_N);

  sequence s_wr_port;
    PSEL && PENABLE && PREADY && PWRITE && PADDR == OFF_LEVEL;
  endsequence

  sequence s_wr_latch;
    PSEL && PENABLE && PREADY && PWRITE && PADDR == OFF_LATCH;
  endsequence

  sequence s_rd_start(logic [7:0] off);
    PSEL && !PENABLE && !PWRITE && PADDR == off
      ##1 PSEL && PENABLE && !PREADY && PADDR == off;
  endsequence

  // The pad lags the pull-up register by one edge, so compare with the
  // value the register held when the pad was loaded
  property p_pin3_never_driven;
    PAD.oe_n[3] && (PAD.pu_en[3] == $past(wpu_q[3]));
  endproperty
  a_pin3_never_driven: assert property (p_pin3_never_driven)
    else $error("pin three driver or pull-up wrong");

  property p_dir_in_off;
    1 |=> ((PAD.oe_n | ~$past(dir_q)) == 6'h3F);
  endproperty
  a_dir_in_off: assert property (p_dir_in_off)
    else $error("input pin still driven");

  property p_dir_out_drives;
    1 |=> ((~$past(dir_q) & ~$past(od_q) & ~$past(pen_q)
            & (PAD.oe_n | (PAD.out ^ $past(lat_q)))) == 6'h00);
  endproperty
  a_dir_out_drives: assert property (p_dir_out_drives)
    else $error("output pin not driving latch value");

  property p_analog_keeps_driver;
    1 |=> ((~$past(dir_q) & ~$past(od_q) & $past(ans_q)
            & ~INPUT_ONLY_MASK & PAD.oe_n) == 6'h00);
  endproperty
  a_analog_keeps_driver: assert property (p_analog_keeps_driver)
    else $error("analog select switched off a driver");

  property p_port_write_merge;
    s_wr_port |=> lat_q == (($past(pin_s) & ~MERGE_MASK)
                            | ($past(wdata6) & MERGE_MASK));
  endproperty
  a_port_write_merge: assert property (p_port_write_merge)
    else $error("port write did not merge into latch");

  property p_latch_write_same;
    s_wr_latch |=> lat_q == (($past(pin_s) & ~MERGE_MASK)
                             | ($past(wdata6) & MERGE_MASK));
  endproperty
  a_latch_write_same: assert property (p_latch_write_same)
    else $error("latch write differs from port write");

  property p_latch_read;
    s_rd_start(OFF_LATCH) |=> PREADY && PRDATA[5:0] == $past(lat_q);
  endproperty
  a_latch_read: assert property (p_latch_read)
    else $error("latch read did not return latch");

  property p_level_read;
    s_rd_start(OFF_LEVEL) |=> PREADY
      && PRDATA[5:0] == ($past(pin_s) & ~$past(ans_q));
  endproperty
  a_level_read: assert property (p_level_read)
    else $error("level read wrong or analog pin not zero");

  property p_ibuf_off;
    1 |=> PAD.ibuf_en == ~$past(ans_q);
  endproperty
  a_ibuf_off: assert property (p_ibuf_off)
    else $error("input buffer not following analog select");

  property p_open_drain_sink;
    1 |=> ((PAD.out & $past(od_q)) == 6'h00)
      && ((~PAD.oe_n & $past(od_q) & $past(drive)) == 6'h00);
  endproperty
  a_open_drain_sink: assert property (p_open_drain_sink)
    else $error("open-drain pin sourced current");

  property p_periph_override;
    1 |=> ((~$past(dir_q) & ~$past(od_q) & $past(pen_q)
            & ~INPUT_ONLY_MASK
            & (PAD.out ^ $past(PERIPH_DATA))) == 6'h00);
  endproperty
  a_periph_override: assert property (p_periph_override)
    else $error("peripheral did not own pin output");

  property p_reset_analog;
    !$past(RST_N) |-> ans_q == RESET_ANALOG && dir_q == RESET_DIR;
  endproperty
  a_reset_analog: assert property (p_reset_analog)
    else $error("reset values of analog or direction wrong");

  property p_pullup_off;
    1 |=> ((PAD.pu_en & ~$past(dir_q)) == 6'h00);
  endproperty
  a_pullup_off: assert property (p_pullup_off)
    else $error("pull-up left on for output pin");

  property p_sync_delay;
    ($past(RST_N) && $past(RST_N, 2)) |-> pin_s == $past(PAD_IN, 2);
  endproperty
  a_sync_delay: assert property (p_sync_delay)
    else $error("pin sample not two cycles behind pad");

  property p_dir_store;
    PSEL && PENABLE && PREADY && PWRITE && PADDR == OFF_DIR
      |=> dir_q == ($past(wdata6) | INPUT_ONLY_MASK);
  endproperty
  a_dir_store: assert property (p_dir_store)
    else $error("direction write not stored");

  property p_dir_reads_one;
    s_rd_start(OFF_DIR) |=> PREADY && PRDATA[3];
  endproperty
  a_dir_reads_one: assert property (p_dir_reads_one)
    else $error("pin three direction did not read one");

  property p_six_bits_only;
    PREADY |-> PRDATA[31:6] == 26'h0000000;
  endproperty
  a_six_bits_only: assert property (p_six_bits_only)
    else $error("read data above the six pins not zero");

  // The latch moves only on a port or latch write; anything else
  // touching it would corrupt a later read-modify-write
  property p_latch_only_by_write;
    $changed(lat_q) |-> $past(PSEL && PENABLE && PREADY && PWRITE
                              && (PADDR == OFF_LEVEL
                                  || PADDR == OFF_LATCH));
  endproperty
  a_latch_only_by_write: assert property (p_latch_only_by_write)
    else $error("latch changed without a port write");

endmodule
`default_nettype wire

// >>> tb/sgp_pins.sv
// Board side of the six pads: port drivers, a board driver, pull-ups.
// Assumes the bench sets EXT_EN and EXT_VAL; an undriven pad without its pull-up floats.
`timescale 1ns/1ps
`default_nettype none
module sgp_pins
  import sgp_pkg::*;
(
  input  wire logic       CLOCK,
  input  wire sgp_pad_t   PAD,
  input  wire logic [5:0] EXT_EN,
  input  wire logic [5:0] EXT_VAL,
  output var  logic [5:0] LVL
);
  logic [5:0] last_q;
  always_ff @(posedge CLOCK) begin
    last_q <= LVL;
  end
  // A floating pad shows the inverse of its last level, never a stale copy
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (!PAD.oe_n[i]) LVL[i] = PAD.out[i];
      else if (EXT_EN[i]) LVL[i] = EXT_VAL[i];
      else if (PAD.pu_en[i]) LVL[i] = 1'h1;
      else LVL[i] = ~last_q[i];
    end
  end
endmodule
`default_nettype wire

// >>> tb/sgp_port_tb.sv
// Bench for the six-pin port: APB master, pad model, table of cases.
// Assumes one wait state per APB transfer and a two-edge synchroniser.
`timescale 1ns/1ps
`default_nettype none
module sgp_port_tb;
  import sgp_pkg::*;
  // Pin five is merged from the pad so the read-modify-write is visible
  localparam logic [5:0] MM = 6'h1F;
  typedef struct packed {
    logic [1:0]  k;
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] x;
  } sgp_row_t;
  // k[0] write, k[1] error expected
  localparam sgp_row_t ROWS [16] = '{
    '{2'h0, OFF_DIR,    32'h0,  32'h3F},
    '{2'h0, OFF_LATCH,  32'h0,  32'h00},
    '{2'h0, OFF_ANALOG, 32'h0,  32'h17},
    '{2'h0, OFF_ODRAIN, 32'h0,  32'h00},
    '{2'h0, OFF_PULLUP, 32'h0,  32'h3F},
    '{2'h0, OFF_PERIPH, 32'h0,  32'h00},
    '{2'h1, OFF_LATCH,  32'h0,  32'h0},
    '{2'h0, OFF_LATCH,  32'h0,  32'h20},
    '{2'h1, OFF_LEVEL,  32'h0F, 32'h0},
    '{2'h0, OFF_LATCH,  32'h0,  32'h2F},
    '{2'h1, OFF_ANALOG, 32'h3F, 32'h0},
    '{2'h0, OFF_ANALOG, 32'h0,  32'h17},
    '{2'h3, 8'h1C,      32'h3F, 32'h0},
    '{2'h2, 8'h1C,      32'h0,  32'h0},
    '{2'h1, OFF_DIR,    32'h0,  32'h0},
    '{2'h0, OFF_DIR,    32'h0,  32'h08}
  };
  logic        CLOCK = 1'h0;
  logic        RST_N = 1'h0;
  logic        psel = 1'h0;
  logic        pen = 1'h0;
  logic        pwr = 1'h0;
  logic [7:0]  pa = 8'h0;
  logic [31:0] pwd = 32'h0;
  logic [31:0] prd;
  logic        pready;
  logic        perr;
  logic [5:0]  pin;
  logic [5:0]  pdat = 6'h0;
  logic [5:0]  xval = 6'h30;
  logic [5:0]  xen = 6'h3F;
  sgp_pad_t    pad;
  int          fails = 0;
  int          n_tests = 0;
  int          cyc = 0;
  logic [31:0] r;
  logic        e;

  sgp_port #(.MERGE_MASK(MM)) uut (.CLOCK(CLOCK), .RST_N(RST_N),
    .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd),
    .PRDATA(prd), .PREADY(pready), .PSLVERR(perr), .PAD_IN(pin),
    .PERIPH_DATA(pdat), .PAD(pad));
  sgp_pins pins (.CLOCK(CLOCK), .PAD(pad), .EXT_EN(xen),
    .EXT_VAL(xval), .LVL(pin));

  always #20 CLOCK = ~CLOCK;

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  always @(posedge CLOCK) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rd_v,
                     output logic er);
    @(posedge CLOCK);
    psel <= 1'h1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge CLOCK);
    pen <= 1'h1;
    do @(posedge CLOCK); while (pready !== 1'h1);
    rd_v = prd;
    er = perr;
    psel <= 1'h0;
    pen <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'h0, a, 32'h0, r, e);
    chk(r, x);
  endtask

  initial begin
    repeat (3) @(posedge CLOCK);
    RST_N <= 1'h1;
    foreach (ROWS[i]) begin
      apb(ROWS[i].k[0], ROWS[i].a, ROWS[i].d, r, e);
      if (!ROWS[i].k[0]) chk(r, ROWS[i].x);
      chk(32'(e), 32'(ROWS[i].k[1]));
    end
    // Analog select cleared first so the level reads back the pins; the drivers ignore it
    wr(OFF_ANALOG, 32'h0);
    wr(OFF_LATCH, 32'h3F);
    repeat (4) @(posedge CLOCK);
    chk(32'(pad.oe_n), 32'h08);
    chk(32'(pad.out & 6'h37), 32'h37);
    chk(32'(pad.pu_en), 32'h08);
    chk(32'(pad.ibuf_en), 32'h3F);
    rd(OFF_LEVEL, 32'h37);
    wr(OFF_ANALOG, 32'h17);
    repeat (4) @(posedge CLOCK);
    chk(32'(pad.oe_n), 32'h08);
    chk(32'(pad.ibuf_en), 32'h28);
    rd(OFF_LEVEL, 32'h20);
    wr(OFF_ANALOG, 32'h0);
    wr(OFF_ODRAIN, 32'h3F);
    wr(OFF_LATCH, 32'h15);
    repeat (2) @(posedge CLOCK);
    chk(32'(pad.oe_n), 32'h3D);
    chk(32'(pad.out), 32'h00);
    wr(OFF_ODRAIN, 32'h0);
    wr(OFF_PERIPH, 32'h3F);
    pdat <= 6'h2A;
    repeat (4) @(posedge CLOCK);
    chk(32'(pad.out & 6'h37), 32'h22);
    rd(OFF_LEVEL, 32'h22);
    rd(OFF_LATCH, 32'h35);
    wr(OFF_PERIPH, 32'h0);
    wr(OFF_DIR, 32'h3F);
    xval <= 6'h15;
    repeat (4) @(posedge CLOCK);
    chk(32'(pad.pu_en), 32'h3F);
    rd(OFF_LEVEL, 32'h15);
    rd(OFF_LATCH, 32'h35);
    // Board lets go of every pad: only the weak pull-ups hold them high
    xen <= 6'h00;
    repeat (4) @(posedge CLOCK);
    rd(OFF_LEVEL, 32'h3F);
    wr(OFF_PULLUP, 32'h00);
    xen <= 6'h3F;
    repeat (2) @(posedge CLOCK);
    chk(32'(pad.pu_en), 32'h00);
    // Reset in mid-run returns the pads to their idle state
    RST_N <= 1'h0;
    repeat (3) @(posedge CLOCK);
    chk(32'(pad), 32'(RESET_PAD));
    RST_N <= 1'h1;
    rd(OFF_ANALOG, 32'h17);
    tally_and_finish();
  end
endmodule
`default_nettype wire
